// ---- asf_defines.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef ASF_DEFINES_SVH
`define ASF_DEFINES_SVH
// Byte offsets on the register bus
`define ASF_MODE_OFS 5'h00
`define ASF_CTRL_OFS 5'h04
`define ASF_DIV_OFS 5'h08
`define ASF_TXD_OFS 5'h0C
`define ASF_RXD_OFS 5'h10
`define ASF_STAT_OFS 5'h14
// mode_register fields
`define ASF_M_SYNC 7
`define ASF_M_LEN7 6
`define ASF_M_PAR 5
`define ASF_M_ODD 4
`define ASF_M_STOP2 3
`define ASF_M_ADR 2
// control_register fields
`define ASF_C_CKE_LOW 0
`define ASF_C_CKE_HIGH 1
`define ASF_C_ADR_BIT 2
`define ASF_C_RX_EN 4
`define ASF_C_TX_EN 5
// Status fields
`define ASF_S_TX_EMPTY 0
`define ASF_S_TX_END 1
`define ASF_S_RX_FULL 2
`define ASF_S_OVR 3
`define ASF_S_PERR 4
`define ASF_S_FERR 5
// Reset values
`define ASF_MODE_RST 8'h00
`define ASF_CTRL_RST 8'h00
`define ASF_DIV_RST 8'h00
// Oversampling: sample tick index and last phase of a bit
`define ASF_SAMPLE 4'h7
`define ASF_LAST_PH 4'hF
`endif

// ---- asf_pkg.sv ----
// Types shared by the serial port files
`default_nettype none
package asf_pkg;
  typedef enum logic [1:0] {ASF_RX_IDLE, ASF_RX_START, ASF_RX_DATA, ASF_RX_STOP} asf_rx_state_t;
endpackage : asf_pkg
`default_nettype wire

// ---- asf_tx.sv ----
// Double buffered asynchronous transmitter
`timescale 1ns/100ps
`default_nettype none
`include "asf_defines.svh"
module asf_tx (
  input wire logic sys_clk_i, // System clock
  input wire logic rstn_i, // Sync reset, low
  input wire logic tick_i, // 16x bit rate tick
  input wire logic en_i, // Transmitter on
  input wire logic len7_i, // Seven data bits
  input wire logic par_en_i, // Parity bit on
  input wire logic par_odd_i, // Odd parity
  input wire logic adr_en_i, // Address flag format
  input wire logic adr_bit_i, // Address flag value
  input wire logic stop2_i, // Two stop bits
  input wire logic wr_i, // Load holding register
  input wire logic [7:0] wdata_i, // Data to send
  output logic empty_o, // Holding register empty
  output logic end_o, // Nothing left to shift; rises as the last stop bit starts
  output logic txd_o, // Serial out
  output logic [3:0] phase_o // Phase within bit
);
  import asf_pkg::*;
  logic [7:0] hold_q;
  logic full_q;
  logic [11:0] sh_q;
  logic [3:0] cnt_q;
  logic [3:0] ph_q;
  logic txd_q;
  logic bound;
  logic xbit;
  logic [11:0] frame;
  logic [3:0] flen;

  assign bound = tick_i & (ph_q == `ASF_LAST_PH);
  assign empty_o = ~full_q;
  assign end_o = ~full_q & (cnt_q == 4'h0);
  assign txd_o = txd_q;
  assign phase_o = ph_q;

  // Frame after start: data, flag or parity, stops (pad is mark)
  always_comb begin
    xbit = adr_en_i ? adr_bit_i : ((^(hold_q & {~len7_i, 7'h7F})) ^ par_odd_i);
    frame = 12'hFFF;
    frame[7:0] = hold_q;
    if (len7_i) begin
      frame[7] = (adr_en_i | par_en_i) ? xbit : 1'b1;
    end else begin
      frame[8] = (adr_en_i | par_en_i) ? xbit : 1'b1;
    end
    flen = 4'h8 + {3'h0, ~len7_i} + {3'h0, adr_en_i | par_en_i} + {3'h0, stop2_i};
  end

  ////////////////////////////////////////////////////////////////////
  // free running bit phase
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ph_q <= 4'h0;
    end else if (tick_i) begin
      ph_q <= ph_q + 4'h1;
    end
  end

  // holding register, emptied as the shifter loads it
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !en_i) begin
      full_q <= 1'b0;
      hold_q <= 8'h00;
    end else if (bound && cnt_q == 4'h0 && full_q) begin
      full_q <= 1'b0;
    end else if (wr_i && !full_q) begin
      full_q <= 1'b1;
      hold_q <= wdata_i;
    end
  end

  // start, data LSB first, extra bit, stops
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !en_i) begin
      cnt_q <= 4'h0;
      sh_q <= 12'hFFF;
      txd_q <= 1'b1;
    end else if (bound) begin
      // Last stop still goes out before the next start bit
      if (cnt_q != 4'h0) begin
        txd_q <= sh_q[0];
        sh_q <= {1'b1, sh_q[11:1]};
        cnt_q <= cnt_q - 4'h1;
      end else if (full_q) begin
        txd_q <= 1'b0;
        sh_q <= frame;
        cnt_q <= flen;
      end else begin
        txd_q <= 1'b1;
      end
    end
  end
endmodule : asf_tx
`default_nettype wire

// ---- asf_rx.sv ----
// Asynchronous receiver with mid-bit sampling
`timescale 1ns/100ps
`default_nettype none
`include "asf_defines.svh"
module asf_rx (
  input wire logic sys_clk_i, // System clock
  input wire logic rstn_i, // Sync reset, low
  input wire logic tick_i, // 16x bit rate tick
  input wire logic en_i, // Receiver on
  input wire logic rxd_i, // Synchronised line
  input wire logic len7_i, // Seven data bits
  input wire logic par_en_i, // Parity check on
  input wire logic par_odd_i, // Odd parity
  input wire logic adr_en_i, // Address flag format
  output logic busy_o, // Character in progress
  output logic done_o, // Character complete pulse
  output logic [7:0] data_o, // Received data
  output logic xbit_o, // Received flag bit
  output logic perr_o, // Parity mismatch
  output logic ferr_o // Stop bit low
);
  import asf_pkg::*;
  asf_rx_state_t st_q;
  logic [3:0] cnt_q;
  logic [3:0] nb_q;
  logic [8:0] sh_q;
  logic [3:0] nfr;
  logic [8:0] al;
  logic [7:0] dat;
  logic xb;

  // Align shifted bits to the bottom
  always_comb begin
    nfr = 4'h7 + {3'h0, ~len7_i} + {3'h0, par_en_i | adr_en_i};
    al = sh_q >> (4'h9 - nfr);
    dat = len7_i ? {1'b0, al[6:0]} : al[7:0];
    xb = len7_i ? al[7] : al[8];
  end

  assign busy_o = (st_q != ASF_RX_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Character framing state machine
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !en_i) begin
      st_q <= ASF_RX_IDLE;
      cnt_q <= 4'h0;
      nb_q <= 4'h0;
      sh_q <= 9'h000;
      done_o <= 1'b0;
      data_o <= 8'h00;
      xbit_o <= 1'b0;
      perr_o <= 1'b0;
      ferr_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (tick_i) begin
        case (st_q)
          ASF_RX_IDLE: begin
            if (!rxd_i) begin
              cnt_q <= 4'h1;
              st_q <= ASF_RX_START;
            end
          end
          default: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `ASF_SAMPLE) begin
              case (st_q)
                ASF_RX_START: begin
                  // Glitch shorter than half a bit is dropped
                  st_q <= rxd_i ? ASF_RX_IDLE : ASF_RX_DATA;
                  nb_q <= nfr;
                end
                ASF_RX_DATA: begin
                  sh_q <= {rxd_i, sh_q[8:1]};
                  nb_q <= nb_q - 4'h1;
                  if (nb_q == 4'h1) begin
                    st_q <= ASF_RX_STOP;
                  end
                end
                default: begin
                  done_o <= 1'b1;
                  data_o <= dat;
                  xbit_o <= xb;
                  perr_o <= par_en_i & ~adr_en_i & ((^dat) ^ xb ^ par_odd_i);
                  ferr_o <= ~rxd_i;
                  st_q <= ASF_RX_IDLE;
                end
              endcase
            end
          end
        endcase
      end
    end
  end
endmodule : asf_rx
`default_nettype wire

// ---- asf_top.sv ----
// Serial port: clock source select, registers and framing core
//
// Function
// - Async 00: baud generator, clock pin unused
// - Async 01: internal clock, drive bit clock
// - Async ext: pin clock at 16x rate
// - Sync internal: drive clock out always
// - Sync external: run from pin clock
// - Mode bit 7 picks sync or async
// - Each character framed by start, stop
// - Independent transmit and receive sections
// - Both directions double buffered
// - Idle line held high
// - Low line marks a start bit
// - Start, data LSB first, parity, stops
// - Receive timing aligned to start edge
// - Sample on eighth 16x tick
// - Mode bits choose format; flag beats parity
// - Baud generator or external pin clock
// - Output clock rises mid data bit
// - Seven or eight data bits
// - Parity or flag; one or two stops
// - Check parity and first stop only
`timescale 1ns/100ps
`default_nettype none
`include "asf_defines.svh"
module asf_top (
  input wire logic sys_clk_i, // 25 MHz clock
  input wire logic rstn_i, // Sync reset, low
  input wire logic [4:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall request
  input wire logic rxd_i, // Serial in pin
  output logic txd_o, // Serial out pin
  input wire logic sck_i, // Clock pin level
  output logic sck_o, // Clock pin drive
  output logic sck_oe_o // Clock pin enable
);
  import asf_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic ack_q;
  logic req;
  logic wr_acc;
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [7:0] div_q;
  logic [7:0] bcnt_q;
  logic int_tick;
  logic rx_s1_q;
  logic rx_s2_q;
  logic ck_s1_q;
  logic ck_s2_q;
  logic ck_s3_q;
  logic ck_rise;
  logic tick;
  logic async_m;
  logic ext_clk;
  logic tx_on;
  logic rx_on;
  logic tx_empty;
  logic tx_end;
  logic [3:0] tx_ph;
  logic rx_busy;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_xbit;
  logic rx_perr;
  logic rx_ferr;
  logic [8:0] rdr_q;
  logic full_q;
  logic ovr_q;
  logic perr_q;
  logic ferr_q;
  logic err_any;
  logic [5:0] stat;
  logic clr_full;
  logic clr_ovr;
  logic clr_perr;
  logic clr_ferr;

  ////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, read data captured in that state
  assign req = avs_read_i | avs_write_i;
  assign wr_acc = avs_write_i & ack_q;
  assign avs_waitrequest_o = req & ~ack_q;

  // Accept on the second cycle of every request
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        `ASF_MODE_OFS: avs_readdata_o <= {24'h00_0000, mode_q};
        `ASF_CTRL_OFS: avs_readdata_o <= {24'h00_0000, ctrl_q};
        `ASF_DIV_OFS: avs_readdata_o <= {24'h00_0000, div_q};
        `ASF_RXD_OFS: avs_readdata_o <= {23'h00_0000, rdr_q};
        `ASF_STAT_OFS: avs_readdata_o <= {26'h000_0000, stat};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Mode, control and divisor registers
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      mode_q <= `ASF_MODE_RST;
      ctrl_q <= `ASF_CTRL_RST;
      div_q <= `ASF_DIV_RST;
    end else if (wr_acc) begin
      if (avs_address_i == `ASF_MODE_OFS) begin
        mode_q <= avs_writedata_i[7:0];
      end
      if (avs_address_i == `ASF_CTRL_OFS) begin
        ctrl_q <= avs_writedata_i[7:0];
      end
      if (avs_address_i == `ASF_DIV_OFS) begin
        div_q <= avs_writedata_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers; rxd uses the second stage, the clock edge detect the second and third
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
    end else begin
      rx_s1_q <= rxd_i;
      rx_s2_q <= rx_s1_q;
      ck_s1_q <= sck_i;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
    end
  end

  // External clock must stay below a quarter of the system clock
  assign ck_rise = ck_s2_q & ~ck_s3_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      bcnt_q <= 8'h00;
    end else if (bcnt_q >= div_q) begin
      bcnt_q <= 8'h00;
    end else begin
      bcnt_q <= bcnt_q + 8'h01;
    end
  end
  assign int_tick = (bcnt_q >= div_q);

  assign async_m = ~mode_q[`ASF_M_SYNC];
  assign ext_clk = ctrl_q[`ASF_C_CKE_HIGH];
  assign tick = ext_clk ? ck_rise : int_tick;

  // Framing runs only in async mode; sync transfer is not built
  assign tx_on = async_m & ctrl_q[`ASF_C_TX_EN];
  // Receive stays halted while any error flag is up
  assign rx_on = async_m & ctrl_q[`ASF_C_RX_EN] & ~err_any;

  ////////////////////////////////////////////////////////////////////
  // Clock pin direction and drive
  always_comb begin
    if (async_m) begin
      sck_oe_o = ~ext_clk & ctrl_q[`ASF_C_CKE_LOW];
    end else begin
      sck_oe_o = ~ext_clk;
    end
    sck_o = sck_oe_o & tx_ph[3];
  end

  ////////////////////////////////////////////////////////////////////
  // separate transmit section
  asf_tx u_tx (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick),
    .en_i(tx_on),
    .len7_i(mode_q[`ASF_M_LEN7]),
    .par_en_i(mode_q[`ASF_M_PAR]),
    .par_odd_i(mode_q[`ASF_M_ODD]),
    .adr_en_i(mode_q[`ASF_M_ADR]),
    .adr_bit_i(ctrl_q[`ASF_C_ADR_BIT]),
    .stop2_i(mode_q[`ASF_M_STOP2]),
    .wr_i(wr_acc && avs_address_i == `ASF_TXD_OFS),
    .wdata_i(avs_writedata_i[7:0]),
    .empty_o(tx_empty),
    .end_o(tx_end),
    .txd_o(txd_o),
    .phase_o(tx_ph)
  );

  asf_rx u_rx (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tick_i(tick),
    .en_i(rx_on),
    .rxd_i(rx_s2_q),
    .len7_i(mode_q[`ASF_M_LEN7]),
    .par_en_i(mode_q[`ASF_M_PAR]),
    .par_odd_i(mode_q[`ASF_M_ODD]),
    .adr_en_i(mode_q[`ASF_M_ADR]),
    .busy_o(rx_busy),
    .done_o(rx_done),
    .data_o(rx_data),
    .xbit_o(rx_xbit),
    .perr_o(rx_perr),
    .ferr_o(rx_ferr)
  );

  ////////////////////////////////////////////////////////////////////
  // Status write-one-to-clear strobes
  assign clr_full = wr_acc & (avs_address_i == `ASF_STAT_OFS) & avs_writedata_i[`ASF_S_RX_FULL];
  assign clr_ovr = wr_acc & (avs_address_i == `ASF_STAT_OFS) & avs_writedata_i[`ASF_S_OVR];
  assign clr_perr = wr_acc & (avs_address_i == `ASF_STAT_OFS) & avs_writedata_i[`ASF_S_PERR];
  assign clr_ferr = wr_acc & (avs_address_i == `ASF_STAT_OFS) & avs_writedata_i[`ASF_S_FERR];
  assign err_any = ovr_q | perr_q | ferr_q;
  assign stat = {ferr_q, perr_q, ovr_q, full_q, tx_end, tx_empty};

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdr_q <= 9'h000;
      full_q <= 1'b0;
      ovr_q <= 1'b0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      if (clr_full) full_q <= 1'b0;
      if (clr_ovr) ovr_q <= 1'b0;
      if (clr_perr) perr_q <= 1'b0;
      if (clr_ferr) ferr_q <= 1'b0;
      if (rx_done) begin
        if (full_q && !clr_full) begin
          ovr_q <= 1'b1;
        end else if (rx_perr || rx_ferr) begin
          perr_q <= rx_perr | (perr_q & ~clr_perr);
          ferr_q <= rx_ferr | (ferr_q & ~clr_ferr);
        end else begin
          full_q <= 1'b1;
          rdr_q <= {rx_xbit, rx_data};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_pin_unused;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (async_m && !ext_clk && !ctrl_q[`ASF_C_CKE_LOW]) |-> !sck_oe_o;
  endproperty
  a_pin_unused: assert property (p_pin_unused) else $error("clock pin driven in mode 00");

  property p_mid_edge;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (sck_oe_o && $past(sck_oe_o) && async_m && $rose(sck_o)) |-> (tx_ph == 4'h8);
  endproperty
  a_mid_edge: assert property (p_mid_edge) else $error("clock rise not at bit centre");

  property p_sync_drive;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (!async_m && !ext_clk) |-> sck_oe_o;
  endproperty
  a_sync_drive: assert property (p_sync_drive) else $error("sync clock not driven");

  property p_ext_tick;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ext_clk |-> (!sck_oe_o && (tick == (ck_s2_q && !ck_s3_q)));
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("external clock not used");

  property p_idle_mark;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (!tx_on ##1 !tx_on) |-> txd_o;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle line not high");

  property p_start_bound;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $fell(txd_o) |-> ($past(tx_ph) == 4'hF && $past(tick));
  endproperty
  a_start_bound: assert property (p_start_bound) else $error("start bit off boundary");

  property p_start_detect;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (rx_on && !rx_busy && tick && !rx_s2_q) ##1 rx_on |-> rx_busy;
  endproperty
  a_start_detect: assert property (p_start_detect) else $error("start bit missed");

  property p_sync_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      mode_q[`ASF_M_SYNC] |-> (!tx_on && !rx_on);
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("framing active in sync mode");

  property p_tx_load;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (wr_acc && avs_address_i == `ASF_TXD_OFS && tx_on && tx_empty) ##1 tx_on |-> !tx_empty;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("transmit write lost");

  property p_overrun;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (rx_done && full_q && !clr_full) |=> (ovr_q && $stable(rdr_q));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
endmodule : asf_top
`default_nettype wire

// ---- asf_peer.sv ----
// Remote serial device: frame sender, frame catcher, external clock
`timescale 1ns/100ps
`default_nettype none
module asf_peer (
  input wire logic sys_clk_i, // System clock
  input wire logic line_i, // Line from device
  output logic line_o, // Line to device
  output logic sck_o // External clock
);
  logic sck_run = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // Idle line marks high between characters
  // idle marking
  initial line_o = 1'b1;
  // Runs only while sck_run is set, held low otherwise; off the system grid
  // external clock
  initial begin
    sck_o = 1'b0;
    #7;
    forever #130 sck_o = sck_run ? ~sck_o : 1'b0;
  end
  // Edge clocks of data bits may be noisy; the middle is clean
  // frame order
  task automatic send(input logic [11:0] b, input int n, input int bt, input bit nz);
    for (int i = 0; i < n; i++) begin
      for (int c = 0; c < bt; c++) begin
        @(posedge sys_clk_i);
        line_o <= (nz && i > 0 && i < 9 && (c < 2 || c >= bt - 2)) ? ~b[i] : b[i];
      end
    end
    @(posedge sys_clk_i);
    line_o <= 1'b1;
  endtask : send
  // Samples mid bit; stops in the last bit so back to back frames are seen
  task automatic grab(input int n, input int bt, output logic [11:0] b, output realtime t0);
    b = '1;
    @(negedge line_i);
    t0 = $realtime;
    repeat (bt / 2) @(posedge sys_clk_i);
    for (int i = 0; i < n; i++) begin
      b[i] = line_i;
      if (i < n - 1) repeat (bt) @(posedge sys_clk_i);
    end
  endtask : grab
endmodule : asf_peer
`default_nettype wire

// ---- tb_top.sv ----
// Testbench for the serial port top level
`timescale 1ns/100ps
`default_nettype none
`include "asf_defines.svh"
module tb_top;
  logic clk, rstn, rd, wr, txd, sck_drv, sck_oe, peer_sck, rxd, wait_req;
  logic [4:0] adr;
  logic [31:0] wdata, rdata;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] tm [6] = '{8'h00, 8'h08, 8'h60, 8'h30, 8'h24, 8'h4C};
  logic [7:0] tc [6] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h34, 8'h30};
  logic [7:0] td [6] = '{8'h55, 8'hA3, 8'hDA, 8'h80, 8'hC6, 8'h7F};
  logic [4:0] ofs [4] = '{`ASF_MODE_OFS, `ASF_CTRL_OFS, `ASF_DIV_OFS, 5'h18};
  // Clock pin wire level from both drivers
  wire logic sck_w = sck_oe ? sck_drv : peer_sck;
  asf_top u_dut (.sys_clk_i(clk), .rstn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .rxd_i(rxd), .txd_o(txd), .sck_i(sck_w),
    .sck_o(sck_drv), .sck_oe_o(sck_oe));
  asf_peer u_peer (.sys_clk_i(clk), .line_i(txd), .line_o(rxd), .sck_o(peer_sck));
  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1
  // Held until waitrequest low at a rising edge; data taken in that cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    chk1("waitrequest", 1'b0, wait_req);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // Transmitter off while the format changes
  task automatic set_mode(input logic [7:0] m, input logic [7:0] c);
    logic [31:0] q;
    bus(1'b1, `ASF_CTRL_OFS, 32'h0, q);
    bus(1'b1, `ASF_MODE_OFS, {24'h0, m}, q);
    bus(1'b1, `ASF_CTRL_OFS, {24'h0, c}, q);
  endtask : set_mode
  // Expected line bits, start first; n gets the bit count
  function automatic logic [11:0] frame(input logic [7:0] m, input logic fl,
                                        input logic [7:0] d, output int n);
    logic [11:0] b;
    logic [7:0] v;
    b = '1;
    b[0] = 1'b0;
    v = m[6] ? (d & 8'h7F) : d;
    for (int i = 0; i < (m[6] ? 7 : 8); i++) b[i + 1] = v[i];
    n = m[6] ? 8 : 9;
    if (m[2] || m[5]) begin
      b[n] = m[2] ? fl : (^v ^ m[4]);
      n++;
    end
    n = n + (m[3] ? 2 : 1);
    return b;
  endfunction : frame
  task automatic tx_one(input logic [7:0] m, input logic [7:0] c, input logic [7:0] d,
                        input int bt);
    logic [11:0] e, g;
    logic [31:0] q;
    int n;
    realtime t;
    e = frame(m, c[2], d, n);
    fork
      u_peer.grab(n, bt, g, t);
      bus(1'b1, `ASF_TXD_OFS, {24'h0, d}, q);
    join
    chk("tx frame", {20'h0, e}, {20'h0, g});
  endtask : tx_one
  task automatic rx_send(input logic [7:0] m, input logic [7:0] d, input logic [11:0] x,
                         input bit nz);
    logic [11:0] b;
    int n;
    b = frame(m, 1'b0, d, n);
    u_peer.send(b ^ x, n, 16, nz);
  endtask : rx_send
  // Status is {frame err, parity err, overrun, full}; cleared afterwards
  task automatic rx_chk(input logic [3:0] st, input logic [7:0] d);
    logic [31:0] q;
    repeat (4) @(posedge clk);
    bus(1'b0, `ASF_STAT_OFS, 32'h0, q);
    chk("rx status", {28'h0, st}, {28'h0, q[5:2]});
    if (st[0]) begin
      bus(1'b0, `ASF_RXD_OFS, 32'h0, q);
      chk("rx data", {24'h0, d}, {24'h0, q[7:0]});
    end
    bus(1'b1, `ASF_STAT_OFS, 32'h3C, q);
  endtask : rx_chk
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] q;
    logic [11:0] g, g2;
    int n;
    realtime t1, t2;
    rstn = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wdata = 32'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ofs[i], 32'h0, q);
      chk("reset or unmapped read", 32'h0, q);
    end
    bus(1'b0, `ASF_STAT_OFS, 32'h0, q);
    chk1("tx empty", 1'b1, q[0]);
    chk1("tx end", 1'b1, q[1]);
    chk1("idle line", 1'b1, txd);
    chk1("clock pin enable", 1'b0, sck_oe);
    for (int i = 0; i < 8; i++) begin
      set_mode({i[2], 7'h0}, {6'h0, i[1:0]});
      @(negedge clk);
      chk1("clock pin enable", i[2] ? !i[1] : (!i[1] && i[0]), sck_oe);
    end
    for (int i = 0; i < 6; i++) begin
      set_mode(tm[i], tc[i]);
      tx_one(tm[i], tc[i], td[i], 16);
    end
    set_mode(8'h00, 8'h30);
    fork
      begin
        u_peer.grab(10, 16, g, t1);
        u_peer.grab(10, 16, g2, t2);
      end
      begin
        bus(1'b1, `ASF_TXD_OFS, 32'h01, q);
        do bus(1'b0, `ASF_STAT_OFS, 32'h0, q); while (q[0] !== 1'b1);
        bus(1'b1, `ASF_TXD_OFS, 32'h02, q);
      end
    join
    chk("first frame", {20'h0, frame(8'h00, 1'b0, 8'h01, n)}, {20'h0, g});
    chk("second frame", {20'h0, frame(8'h00, 1'b0, 8'h02, n)}, {20'h0, g2});
    chk1("no gap", 1'b1, (t2 - t1) == 6400.0);
    // Bit clock on the pin rises half a bit after each boundary
    set_mode(8'h00, 8'h31);
    fork
      tx_one(8'h00, 8'h31, 8'h55, 16);
      begin
        @(negedge txd);
        t1 = $realtime;
        @(posedge sck_drv);
        chk1("clock rise mid bit", 1'b1, ($realtime - t1) == 320.0);
      end
    join
    set_mode(8'h00, 8'h30);
    fork
      begin
        rx_send(8'h00, 8'hA5, 12'h000, 1'b1);
        rx_chk(4'b0001, 8'hA5);
      end
      tx_one(8'h00, 8'h30, 8'h96, 16);
    join
    set_mode(8'h60, 8'h30);
    rx_send(8'h60, 8'hDA, 12'h000, 1'b0);
    rx_chk(4'b0001, 8'h5A);
    set_mode(8'h30, 8'h30);
    rx_send(8'h30, 8'h3C, 12'h200, 1'b0);
    rx_chk(4'b0100, 8'h00);
    set_mode(8'h00, 8'h30);
    rx_send(8'h00, 8'h3C, 12'h200, 1'b0);
    rx_chk(4'b1000, 8'h00);
    rx_send(8'h00, 8'h11, 12'h000, 1'b0);
    rx_send(8'h00, 8'h22, 12'h000, 1'b0);
    rx_chk(4'b0011, 8'h11);
    set_mode(8'h00, 8'h32);
    u_peer.sck_run = 1'b1;
    @(negedge clk);
    chk1("clock pin enable", 1'b0, sck_oe);
    tx_one(8'h00, 8'h32, 8'h4E, 104);
    u_peer.sck_run = 1'b0;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
